/* File: inc/timer_pkg.sv */
package timer_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned    ADDR_W         = 8;
  localparam logic [7:0]     OFF_TIMER      = 8'h01;
  localparam logic [7:0]     OFF_OPTION     = 8'h20;
  localparam logic [7:0]     OFF_DIRECTION  = 8'h21;
  localparam logic [7:0]     OFF_COMMAND    = 8'h22;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int unsigned    CMD_WDT_CLEAR_BIT = 0;
  localparam int unsigned    SHARED_PIN_BIT    = 2;
  localparam logic [7:0]     OPTION_RESET      = 8'hFF;
  localparam logic [5:0]     DIRECTION_RESET   = 6'h3F;
  localparam logic [5:0]     SHARED_PIN_MASK   = 6'h04;
  localparam logic [7:0]     PRESCALER_RESET   = 8'h00;
  localparam logic [7:0]     RDATA_IDLE        = 8'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned    TOSC_NS           = 20;
  localparam int unsigned    INHIBIT_CYCLES    = 2;
  // one more than the hold-off, since the write cycle itself ends first
  localparam logic [1:0]     INHIBIT_LOAD      = 2'(INHIBIT_CYCLES + 1);
  localparam int unsigned    EXT_DELAY_MIN_OSC = 3;
  localparam int unsigned    EXT_DELAY_MAX_OSC = 7;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_ONE   = 2'h0,
    PH_TWO   = 2'h1,
    PH_THREE = 2'h3,
    PH_FOUR  = 2'h2
  } phase_t;

  typedef struct packed {
    logic       wake_disable;
    logic       pullup_disable;
    logic       clock_source_select;
    logic       source_edge_select;
    logic       prescaler_assign;
    logic [2:0] prescale_rate;
  } option_t;

endpackage : timer_pkg

/* File: verif/count_source.sv */
`timescale 1ns/1ps
// ----
// pulse source on the count pin
// ----
module count_source (
  // clock
  input  wire logic       i_clk,
  // request
  input  wire logic       i_go,
  input  wire logic [7:0] i_pulses,
  input  wire logic [2:0] i_half,
  // pin side
  output logic            o_pin,
  output logic            o_busy
);
  initial begin
    o_pin  = 1'b0;
    o_busy = 1'b0;
  end
  // each level held i_half + 2 edges, never under two periods
  always @(posedge i_clk) begin
    if (i_go && !o_busy) begin
      o_busy <= 1'b1;
      for (int k = 0; k < 2 * int'(i_pulses); k++) begin
        o_pin <= ~o_pin;
        repeat (int'(i_half) + 2) @(posedge i_clk);
      end
      o_busy <= 1'b0;
    end
  end
endmodule : count_source

/* File: verif/timer_with_shared_prescaler_test.sv */
`timescale 1ns/1ps
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t: got %0h want %0h", $time, (g), (e)); end end
module timer_with_shared_prescaler_test;
  // ----
  // signals
  // ----
  logic       mclk, rst_n, wr, rd, tick, tmo, clr, go, busy, pin, rd_d1;
  logic [7:0] addr, wdata, rdata, pulses, d, n;
  logic [2:0] half;
  logic [5:0] dir;
  int         err_total, tests_run, cyc, tmo_cnt, clr_cnt, wait_cnt, t0, c0;
  logic [7:0] exp_q[$];

  timer_prescaler dut_u (.I_MCLK(mclk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_COUNT_INPUT_PIN(pin), .I_WATCHDOG_TICK(tick),
    .O_WATCHDOG_TIMEOUT(tmo), .O_WATCHDOG_CLEAR_OP(clr), .O_PORT_DIRECTION(dir));
  count_source src_u (.i_clk(mclk), .i_go(go), .i_pulses(pulses), .i_half(half),
    .o_pin(pin), .o_busy(busy));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // edge count since release mirrors the phase: Q4 when cyc % 4 == 3
  always @(posedge mclk) begin
    cyc      <= rst_n ? cyc + 1 : 0;
    rd_d1    <= rd;
    tmo_cnt  <= tmo_cnt + int'(tmo === 1'b1);
    clr_cnt  <= clr_cnt + int'(clr === 1'b1);
    wait_cnt <= wait_cnt + 1;
    if (rd_d1) `CHECK(rdata, exp_q.pop_front())
    if (wait_cnt > 30000) begin
      err_total++;
      print_verdict();
    end
  end

  // ----
  // tasks
  // ----
  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
  endtask : do_reset
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd   <= 1'b0;
  endtask : rd_reg
  // next strobe is sampled on phase ph
  task automatic align(input int ph);
    do @(posedge mclk); while (((cyc + 3) % 4) != ph);
  endtask : align
  task automatic ticks(input int nt);
    repeat (nt) begin
      @(posedge mclk);
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
    end
    repeat (3) @(posedge mclk);
  endtask : ticks
  task automatic pin_case(input logic [7:0] opt, input logic [7:0] np, input logic [7:0] inc);
    wr_reg(timer_pkg::OFF_OPTION, opt);
    repeat (4) @(posedge mclk);
    d = 8'($urandom);
    wr_reg(timer_pkg::OFF_TIMER, d);
    repeat (12) @(posedge mclk);
    @(posedge mclk);
    pulses <= np;
    half   <= 3'($urandom_range(3));
    go     <= 1'b1;
    @(posedge mclk);
    go     <= 1'b0;
    do @(posedge mclk); while (busy);
    repeat (12) @(posedge mclk);
    rd_reg(timer_pkg::OFF_TIMER, d + inc);
  endtask : pin_case
  // reads land on Q2 so no read races an increment
  task automatic timer_case(input logic [7:0] v);
    align(0);
    wr_reg(timer_pkg::OFF_TIMER, v);
    for (int k = 0; k < 5; k++) begin
      align(2);
      rd_reg(timer_pkg::OFF_TIMER, v + 8'(k > 1 ? k - 1 : 0));
    end
  endtask : timer_case
  // reads sit half a period away from any increment
  task automatic rate_case(input int r);
    wr_reg(timer_pkg::OFF_COMMAND, 8'h01);
    wr_reg(timer_pkg::OFF_OPTION, 8'(r));
    d = 8'($urandom);
    align(0);
    wr_reg(timer_pkg::OFF_TIMER, d);
    for (int k = 1; k < 3; k++) begin
      repeat ((4 << (r + 1)) - 4) @(posedge mclk);
      rd_reg(timer_pkg::OFF_TIMER, d + 8'(k));
    end
  endtask : rate_case
  task print_verdict();
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ----
  // sequence
  // ----
  initial begin
    void'($urandom(83));
    {rst_n, wr, rd, tick, go, rd_d1} = '0;
    {addr, wdata, pulses, half} = '0;
    {err_total, tests_run, cyc, tmo_cnt, clr_cnt, wait_cnt} = '0;
    do_reset();
    #1 `CHECK(dir, timer_pkg::DIRECTION_RESET)
    d = 8'($urandom);
    wr_reg(timer_pkg::OFF_TIMER, d);
    do_reset();
    rd_reg(timer_pkg::OFF_TIMER, d);
    wr_reg(timer_pkg::OFF_DIRECTION, 8'h00);
    wr_reg(8'h55, 8'hFF);
    @(posedge mclk);
    #1 `CHECK(dir, 6'h04)
    rd_reg(timer_pkg::OFF_OPTION, 8'h00);
    rd_reg(timer_pkg::OFF_DIRECTION, 8'h00);
    rd_reg(8'h55, 8'h00);
    rd_reg(timer_pkg::OFF_TIMER, d);
    n = 8'($urandom_range(20, 1));
    pin_case(8'h28, n, n);
    pin_case(8'h38, n, n);
    wr_reg(timer_pkg::OFF_COMMAND, 8'h01);
    pin_case(8'h20, n << 1, n);
    wr_reg(timer_pkg::OFF_COMMAND, 8'h01);
    wr_reg(timer_pkg::OFF_TIMER, 8'h00);
    wr_reg(timer_pkg::OFF_OPTION, 8'h08);
    repeat (2) @(posedge mclk);
    #1 `CHECK(dir, 6'h00)
    t0 = tmo_cnt;
    ticks(2);
    `CHECK(tmo_cnt - t0, 2)
    timer_case(8'hFE);
    timer_case(8'($urandom));
    for (int r = 2; r < 8; r++) rate_case(r);
    wr_reg(timer_pkg::OFF_COMMAND, 8'h01);
    wr_reg(timer_pkg::OFF_TIMER, 8'h00);
    wr_reg(timer_pkg::OFF_OPTION, 8'h0A);
    t0 = tmo_cnt;
    ticks(8);
    `CHECK(tmo_cnt - t0, 2)
    c0 = clr_cnt;
    t0 = tmo_cnt;
    ticks(3);
    wr_reg(timer_pkg::OFF_COMMAND, 8'h01);
    ticks(3);
    `CHECK(tmo_cnt - t0, 0)
    `CHECK(clr_cnt - c0, 1)
    wr_reg(timer_pkg::OFF_COMMAND, 8'h01);
    wr_reg(timer_pkg::OFF_OPTION, 8'h02);
    t0 = tmo_cnt;
    ticks(4);
    `CHECK(tmo_cnt - t0, 4)
    repeat (4) @(posedge mclk);
    print_verdict();
  end
endmodule : timer_with_shared_prescaler_test

/* File: verilog/timer_prescaler.sv */
`timescale 1ns/1ps
// How it works
// RL1: clear source bit counts instruction cycles
// RL2: count write holds off two instruction cycles
// RL3: set source bit counts pin edges, polarity selectable
// RL4: prescaler serves timer or watchdog, not both
// RL5: timer ratios run 1:2 to 1:256
// RL6: prescaler has no software read or write
// RL7: count write clears timer-owned prescaler
// RL8: watchdog clear clears watchdog-owned prescaler
// RL9: reset loads prescaler with zeros
// RL10: prescaler output sampled in phases two, four
// RL11: pin change to increment three to seven
// RL12: source holds pin two periods each level
// RL13: pin divided by prescaler before sampling
// RL14: external source forces shared pin input
// RL15: count register read/write, untouched by reset
// RL16: software clears watchdog, count before reassigning
// RL17: software clears watchdog before giving prescaler back
// RL18: rate n gives 2^(n+1) timer, 2^n watchdog
// RL19: count wraps silently from FF to 00
module timer_prescaler (
  // clock and reset
  input  wire logic       I_MCLK,
  input  wire logic       I_RST_N,
  // register port
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  // count pin
  input  wire logic       I_COUNT_INPUT_PIN,
  // watchdog side
  input  wire logic       I_WATCHDOG_TICK,
  output logic            O_WATCHDOG_TIMEOUT,
  output logic            O_WATCHDOG_CLEAR_OP,
  // port direction, 1 = input
  output logic      [5:0] O_PORT_DIRECTION
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic low_ones(input logic [7:0] v, input logic [2:0] k);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(k)) begin
        r = r & v[i];
      end
    end
    return r;
  endfunction : low_ones

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  timer_pkg::phase_t  phase_q;
  timer_pkg::phase_t  phase_d;
  timer_pkg::option_t option_q;
  logic [5:0]         port_direction_q;
  logic [7:0]         timer_q;
  logic [7:0]         timer_d;
  logic [7:0]         psc_q;
  logic [1:0]         inhibit_q;
  logic               sync1_q;
  logic               sync2_q;
  logic               pin_prev_q;
  logic               samp_q;
  logic               samp_rise_q;

  logic               wr_timer;
  logic               wr_option;
  logic               wr_port_direction;
  logic               wdt_clear;
  logic               psc_to_timer;
  logic               ext_mode;
  logic               direct_mode;
  logic               quarter_end;
  logic               sample_now;
  logic               pin_level;
  logic               pin_rise;
  logic               psc_tick;
  logic               psc_clear;
  logic               psc_out;
  logic               samp_level;
  logic               raw_inc;
  logic               tmr_inc;

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  assign wr_timer  = I_WR && (I_ADDR == timer_pkg::OFF_TIMER);
  assign wr_option = I_WR && (I_ADDR == timer_pkg::OFF_OPTION);
  assign wr_port_direction   = I_WR && (I_ADDR == timer_pkg::OFF_DIRECTION);
  assign wdt_clear = I_WR && (I_ADDR == timer_pkg::OFF_COMMAND)
                     && I_WDATA[timer_pkg::CMD_WDT_CLEAR_BIT];

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      option_q <= timer_pkg::option_t'(timer_pkg::OPTION_RESET);
    end else if (wr_option) begin
      option_q <= timer_pkg::option_t'(I_WDATA);
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      port_direction_q <= timer_pkg::DIRECTION_RESET;
    end else if (wr_port_direction) begin
      port_direction_q <= I_WDATA[5:0];
    end
  end

  // only the count reads back; option, direction and prescaler are hidden
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_RDATA <= timer_pkg::RDATA_IDLE;
    end else if (I_RD && (I_ADDR == timer_pkg::OFF_TIMER)) begin
      O_RDATA <= timer_q;                                            // [RL15] [RL6]
    end else begin
      O_RDATA <= timer_pkg::RDATA_IDLE;
    end
  end

  // ------------------------------------------------------------
  // instruction-cycle phases
  // ------------------------------------------------------------
  always_comb begin
    unique case (phase_q)
      timer_pkg::PH_ONE:   phase_d = timer_pkg::PH_TWO;
      timer_pkg::PH_TWO:   phase_d = timer_pkg::PH_THREE;
      timer_pkg::PH_THREE: phase_d = timer_pkg::PH_FOUR;
      timer_pkg::PH_FOUR:  phase_d = timer_pkg::PH_ONE;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      phase_q <= timer_pkg::PH_ONE;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign quarter_end = (phase_q == timer_pkg::PH_FOUR);
  assign sample_now  = (phase_q == timer_pkg::PH_TWO) || quarter_end;

  // ------------------------------------------------------------
  // count pin
  // ------------------------------------------------------------
  // no reset: the pair keeps following the pin, so release shows no false edge
  always_ff @(posedge I_MCLK) begin
    sync1_q <= I_COUNT_INPUT_PIN;
    sync2_q <= sync1_q;
  end

  // inverting the pin turns a falling edge into a rising one
  assign pin_level = sync2_q ^ option_q.source_edge_select;          // [RL3]

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      pin_prev_q <= pin_level;                                       // idle level, not 0
    end else begin
      pin_prev_q <= pin_level;
    end
  end

  assign pin_rise = pin_level && !pin_prev_q;

  // ------------------------------------------------------------
  // shared prescaler
  // ------------------------------------------------------------
  assign psc_to_timer = !option_q.prescaler_assign;                  // [RL4]
  assign ext_mode     = option_q.clock_source_select;
  assign direct_mode  = !ext_mode && !psc_to_timer;                  // [RL1]

  // synchronous stand-in for the ripple divider: the pin still only
  // reaches it through the synchroniser, so a fast pin is undercounted
  assign psc_tick  = psc_to_timer ? (ext_mode ? pin_rise : quarter_end)   // [RL13]
                                  : I_WATCHDOG_TICK;                      // [RL4]
  assign psc_clear = (wr_timer && psc_to_timer)                      // [RL7]
                     || (wdt_clear && !psc_to_timer);                // [RL8]

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      psc_q <= timer_pkg::PRESCALER_RESET;                           // [RL9]
    end else if (psc_clear) begin
      psc_q <= timer_pkg::PRESCALER_RESET;
    end else if (psc_tick) begin
      psc_q <= psc_q + 8'h01;
    end
  end

  // bit n toggles every 2^n ticks: a square wave of period 2^(n+1)
  assign psc_out    = psc_q[option_q.prescale_rate];                 // [RL5] [RL18]
  assign samp_level = psc_to_timer ? psc_out : pin_level;

  // ------------------------------------------------------------
  // phase sampling
  // ------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      samp_q      <= samp_level;                                     // keeps count intact [RL15]
      samp_rise_q <= 1'b0;
    end else if (sample_now) begin
      samp_q      <= samp_level;                                     // [RL10]
      samp_rise_q <= samp_level && !samp_q;                          // [RL11]
    end else begin
      samp_rise_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // count register
  // ------------------------------------------------------------
  assign raw_inc = direct_mode ? quarter_end : samp_rise_q;          // [RL1]
  assign tmr_inc = raw_inc && (inhibit_q == 2'h0) && !wr_timer;      // [RL2]

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      inhibit_q <= 2'h0;
    end else if (wr_timer) begin
      // a write on the Q4 edge has no own-cycle Q4 left to count down
      inhibit_q <= quarter_end ? 2'(timer_pkg::INHIBIT_CYCLES)      // [RL2]
                               : timer_pkg::INHIBIT_LOAD;
    end else if (quarter_end && (inhibit_q != 2'h0)) begin
      inhibit_q <= inhibit_q - 2'h1;
    end
  end

  always_comb begin
    timer_d = timer_q;
    if (wr_timer) begin
      timer_d = I_WDATA;
    end else if (tmr_inc) begin
      timer_d = timer_q + 8'h01;                                     // [RL19]
    end
  end

  // no reset here: the count survives every reset
  always_ff @(posedge I_MCLK) begin
    timer_q <= timer_d;                                              // [RL15]
  end

  // ------------------------------------------------------------
  // watchdog and port outputs
  // ------------------------------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_WATCHDOG_TIMEOUT  <= 1'b0;
      O_WATCHDOG_CLEAR_OP <= 1'b0;
    end else begin
      // without the prescaler the watchdog fires on every tick
      O_WATCHDOG_TIMEOUT  <= I_WATCHDOG_TICK                         // [RL18]
                             && (psc_to_timer                        // [RL4]
                                 || low_ones(psc_q, option_q.prescale_rate));
      O_WATCHDOG_CLEAR_OP <= wdt_clear;                              // [RL8]
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_PORT_DIRECTION <= timer_pkg::DIRECTION_RESET;
    end else begin
      O_PORT_DIRECTION <= port_direction_q | (ext_mode ? timer_pkg::SHARED_PIN_MASK : 6'h00); // [RL14]
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  a_timer_mode_step: assert property (                               // [RL1]
    (direct_mode && quarter_end && inhibit_q == 2'h0 && !wr_timer)
      |=> timer_q == $past(timer_q) + 8'h01)
    else $error("timer mode missed an instruction-cycle step");

  a_write_holds_off: assert property (                               // [RL2]
    wr_timer |=> (!tmr_inc) [*8])
    else $error("count advanced inside hold-off after write");

  a_edge_sampled: assert property (                                  // [RL3]
    (ext_mode && !psc_to_timer && $rose(pin_level)) |-> ##[1:2] samp_rise_q)
    else $error("selected pin edge not sampled");

  a_psc_exclusive: assert property (                                 // [RL4]
    (!psc_to_timer && !I_WATCHDOG_TICK && !wdt_clear) |=> $stable(psc_q))
    else $error("watchdog-owned prescaler moved by timer");

  a_psc_write_clear: assert property (                               // [RL7]
    (wr_timer && psc_to_timer) |=> psc_q == timer_pkg::PRESCALER_RESET)
    else $error("count write left prescaler uncleared");

  a_psc_wdt_clear: assert property (                                 // [RL8]
    (wdt_clear && !psc_to_timer)
      |=> (psc_q == timer_pkg::PRESCALER_RESET) && O_WATCHDOG_CLEAR_OP)
    else $error("watchdog clear left prescaler uncleared");

  a_psc_reset_zero: assert property (                                // [RL9]
    @(posedge I_MCLK) disable iff (1'b0)
    !I_RST_N |=> psc_q == timer_pkg::PRESCALER_RESET)
    else $error("prescaler not zero after reset");

  a_sample_phases: assert property (                                 // [RL10]
    samp_rise_q |-> $past(phase_q) == timer_pkg::PH_TWO
                    || $past(phase_q) == timer_pkg::PH_FOUR)
    else $error("prescaler output sampled off phase");

  a_shared_pin_in: assert property (                                 // [RL14]
    ext_mode |=> O_PORT_DIRECTION[timer_pkg::SHARED_PIN_BIT])
    else $error("shared pin not forced to input");

  a_wdt_ratio: assert property (                                     // [RL18]
    (!psc_to_timer && I_WATCHDOG_TICK && option_q.prescale_rate == 3'h0)
      |=> O_WATCHDOG_TIMEOUT)
    else $error("watchdog ratio 1:1 missed a tick");

  a_wdt_unscaled: assert property (                                  // [RL4]
    (psc_to_timer && I_WATCHDOG_TICK) |=> O_WATCHDOG_TIMEOUT)
    else $error("watchdog without prescaler missed a tick");

  a_count_wrap: assert property (                                    // [RL19]
    (tmr_inc && timer_q == 8'hFF) |=> timer_q == 8'h00)
    else $error("count did not wrap to zero");

  a_read_back: assert property (                                     // [RL15]
    (I_RD && I_ADDR == timer_pkg::OFF_TIMER) |=> O_RDATA == $past(timer_q))
    else $error("count read returned wrong value");

  a_read_hidden: assert property (                                   // [RL6]
    !(I_RD && I_ADDR == timer_pkg::OFF_TIMER) |=> O_RDATA == timer_pkg::RDATA_IDLE)
    else $error("hidden register leaked on read port");

  c_timer_wrap: cover property (tmr_inc && timer_q == 8'hFF);
  c_ext_count:  cover property (ext_mode && tmr_inc);
  c_wdt_fire:   cover property (O_WATCHDOG_TIMEOUT);
  c_psc_timer:  cover property (psc_to_timer && !ext_mode && tmr_inc);

endmodule : timer_prescaler
